// ### design/service_slave.sv
// Purpose: slave end of the parameter service channel
// Assumes: own_addr_in is static; master keeps to request order
// Notes: parameter store of NUM_PARAM entries, six stored elements each
`timescale 1ns/100ps
module service_slave
  import svc_pkg::*;
#(
  parameter bit SINGLE_ELEM = 1'b0
) (
  input wire logic sys_clk_in, // 20 MHz clock
  input wire logic rst_b_in, // sync reset, active low
  svc_if.dev link, // mailbox frames
  input wire logic [ADDR_W-1:0] own_addr_in, // this slave's address
  output logic proc_start_out, // one-cycle process start
  output logic [IDENT_W-1:0] proc_ident_out // started process ident
);

  typedef enum {ST_IDLE, ST_EXEC, ST_SEND} dev_state_t;

  dev_state_t state;
  dev_state_t next_state;
  logic [CMD_W-1:0] cmd;
  logic more;
  logic [ELEM_W-1:0] elem;
  logic [IDENT_W-1:0] ident;
  logic [DATA_W-1:0] data;
  logic seg_act;
  logic [IDENT_W-1:0] seg_param;
  logic [ELEM_W-1:0] send_mask;
  logic [DATA_W-1:0] mem [NUM_PARAM][NUM_STORED];

  logic ld;
  logic [CMD_W-1:0] f_cmd;
  logic f_err;
  logic f_more;
  logic [ELEM_W-1:0] f_elem;
  logic [DATA_W-1:0] f_data;
  logic mem_we;
  logic proc_go;
  logic seg_set;
  logic seg_clr;

  // ************************************************************
  // decode
  // ************************************************************
  wire take = link.req_valid && link.req_ready;
  // only addressed mailbox frames are handled
  wire take_me = take && (link.req_addr == own_addr_in);
  wire can_load = !link.rsp_valid || link.rsp_ready;
  // mid-segment frames carry a count, so use the saved ident
  wire [IDENT_W-1:0] param_id = (cmd == CMD_WR_REQ && seg_act) ?
    seg_param : ident;
  // only standard group 0 numbers below NUM_PARAM exist
  wire class_ok = !param_id[ID_CLASS_BIT] &&
    (param_id[ID_GROUP_HI:ID_GROUP_LO] == '0);
  wire param_ok = class_ok &&
    (param_id[ID_NUM_HI:SLOT_W] == '0);
  wire [SLOT_W-1:0] slot = param_id[SLOT_W-1:0];
  // bits above the seventh element name nothing
  wire mask_bad = (elem == '0) || (elem[ELEM_W-1:NUM_ELEM] != '0);

  wire [ELEM_W-1:0] pick_src = (state == ST_SEND) ? send_mask : elem;
  wire [ELEM_W-1:0] pick_first;
  wire [PICK_W-1:0] pick_idx;
  wire [ELEM_W-1:0] pick_rest;

  elem_pick u_pick (
    .mask_in(pick_src),
    .first_out(pick_first),
    .idx_out(pick_idx),
    .rest_out(pick_rest)
  );

  // a single-element slave keeps only the lowest selection
  wire [ELEM_W-1:0] rd_mask = SINGLE_ELEM ? pick_first : elem;
  // element 1 is the identifier itself, the rest live in the store
  wire [DATA_W-1:0] elem_val = (pick_idx == '0) ?
    DATA_W'(param_id) : mem[slot][pick_idx - PICK_W'(1)];

  wire [DATA_W-1:0] p_min = mem[slot][SI_MIN];
  wire [DATA_W-1:0] p_max = mem[slot][SI_MAX];
  wire is_proc = mem[slot][SI_ATTR][ATTR_PROC_BIT];
  wire [ERR_CODE_W-1:0] rd_code = !param_ok ? ERR_NO_PARAM :
    mask_bad ? ERR_BAD_ELEM : ERR_NONE;
  // only the data value element may be written, within its limits
  wire [ERR_CODE_W-1:0] wr_code = !param_ok ? ERR_NO_PARAM :
    (elem != ELEM_DATA_ONLY) ? ERR_READ_ONLY :
    (data < p_min || data > p_max) ? ERR_RANGE : ERR_NONE;

  // ************************************************************
  // sequencer
  // ************************************************************
  always_comb begin
    ld = 1'b0;
    f_cmd = cmd;
    f_err = 1'b0;
    f_more = LAST_FRAG;
    f_elem = elem;
    f_data = '0;
    mem_we = 1'b0;
    proc_go = 1'b0;
    seg_set = 1'b0;
    seg_clr = 1'b0;
    next_state = state;
    case (state)
      ST_IDLE: begin
        // nothing leaves here until a request arrives
        if (take_me) begin
          next_state = ST_EXEC;
        end
      end
      ST_EXEC: begin
        if (can_load) begin
          case (cmd)
            CMD_RD_REQ: begin
              if (rd_code != ERR_NONE) begin
                // error flag and code in the data area
                ld = 1'b1;
                f_cmd = CMD_RD_RSP;
                f_err = 1'b1;
                f_data = DATA_W'(rd_code);
                next_state = ST_IDLE;
              end else begin
                next_state = ST_SEND;
              end
            end
            CMD_WR_REQ: begin
              next_state = ST_IDLE;
              if (more == FOLLOW_ON) begin
                // no answer to a non-final fragment
                seg_set = !seg_act;
              end else begin
                // one write response with the outcome
                seg_clr = 1'b1;
                ld = 1'b1;
                f_cmd = CMD_WR_RSP;
                f_err = (wr_code != ERR_NONE);
                f_data = DATA_W'(wr_code);
                mem_we = (wr_code == ERR_NONE);
                // start the process and answer without waiting
                proc_go = (wr_code == ERR_NONE) && is_proc;
              end
            end
            default: begin
              // echo the code with an error, store untouched
              ld = 1'b1;
              f_err = 1'b1;
              f_data = DATA_W'(ERR_BAD_CMD);
              next_state = ST_IDLE;
            end
          endcase
        end
      end
      ST_SEND: begin
        if (can_load) begin
          // read response with ident and element value
          ld = 1'b1;
          f_cmd = CMD_RD_RSP;
          f_elem = pick_first;
          f_data = elem_val;
          f_more = (pick_rest != '0) ? FOLLOW_ON : LAST_FRAG;
          if (pick_rest == '0) begin
            next_state = ST_IDLE;
          end
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // ************************************************************
  // state and request capture
  // ************************************************************
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      state <= ST_IDLE;
      link.req_ready <= 1'b0;
      cmd <= '0;
      more <= 1'b0;
      elem <= '0;
      ident <= '0;
      data <= '0;
    end else begin
      state <= next_state;
      link.req_ready <= (next_state == ST_IDLE);
      if (take) begin
        cmd <= link.req_cmd;
        more <= link.req_more;
        elem <= link.req_elem;
        ident <= link.req_ident;
        data <= link.req_data;
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      seg_act <= 1'b0;
      seg_param <= '0;
      send_mask <= '0;
    end else begin
      if (seg_set) begin
        seg_act <= 1'b1;
        seg_param <= ident;
      end else if (seg_clr) begin
        seg_act <= 1'b0;
      end
      // walk every element of rd_mask, one frame each
      if (state == ST_EXEC && next_state == ST_SEND) begin
        send_mask <= rd_mask;
      end else if (state == ST_SEND && can_load) begin
        send_mask <= pick_rest;
      end
    end
  end

  // ************************************************************
  // response frame
  // ************************************************************
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      link.rsp_valid <= 1'b0;
      link.rsp_cmd <= '0;
      link.rsp_more <= 1'b0;
      link.rsp_err <= 1'b0;
      link.rsp_addr <= '0;
      link.rsp_elem <= '0;
      link.rsp_ident <= '0;
      link.rsp_data <= '0;
    end else if (ld) begin
      link.rsp_valid <= 1'b1;
      link.rsp_cmd <= f_cmd;
      link.rsp_more <= f_more;
      link.rsp_err <= f_err;
      link.rsp_addr <= own_addr_in;
      link.rsp_elem <= f_elem;
      link.rsp_ident <= param_id;
      link.rsp_data <= f_data;
    end else if (link.rsp_ready) begin
      link.rsp_valid <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      proc_start_out <= 1'b0;
      proc_ident_out <= '0;
    end else begin
      proc_start_out <= proc_go;
      if (proc_go) begin
        proc_ident_out <= param_id;
      end
    end
  end

  // ************************************************************
  // parameter store
  // ************************************************************
  // reset contents stand in for a real table; last slot is a process
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      for (int p = 0; p < NUM_PARAM; p++) begin
        mem[p][SI_NAME] <= DATA_W'(p);
        mem[p][SI_ATTR] <= (SLOT_W'(p) == PROC_SLOT) ? ATTR_PROC : '0;
        mem[p][SI_UNIT] <= '0;
        mem[p][SI_MIN] <= '0;
        mem[p][SI_MAX] <= DEF_MAX;
        mem[p][SI_DATA] <= '0;
      end
    end else if (mem_we) begin
      mem[slot][SI_DATA] <= data;
    end
  end

endmodule

// ### design/svc_pkg.sv
// Purpose: shared constants for the parameter service channel
// Assumes: one 20 MHz clock, frames move as whole headers plus one word
// Notes: error codes and host register offsets are local choices
package svc_pkg;

  // ************************************************************
  // frame layout
  // ************************************************************
  localparam int ADDR_W = 8;
  localparam int ELEM_W = 8;
  localparam int IDENT_W = 16;
  localparam int DATA_W = 32;
  localparam int CMD_W = 3;
  localparam int ERR_CODE_W = 16;

  localparam logic [CMD_W-1:0] CMD_RD_REQ = 3'h1;
  localparam logic [CMD_W-1:0] CMD_RD_RSP = 3'h2;
  localparam logic [CMD_W-1:0] CMD_WR_REQ = 3'h3;
  localparam logic [CMD_W-1:0] CMD_WR_RSP = 3'h4;
  localparam logic FOLLOW_ON = 1'h1;
  localparam logic LAST_FRAG = 1'h0;

  // identifier: class bit, group field, number field
  localparam int ID_CLASS_BIT = 15;
  localparam int ID_GROUP_HI = 14;
  localparam int ID_GROUP_LO = 12;
  localparam int ID_NUM_HI = 11;

  // ************************************************************
  // parameter store
  // ************************************************************
  localparam int NUM_ELEM = 7;
  localparam int NUM_STORED = 6;
  localparam int NUM_PARAM = 8;
  localparam int SLOT_W = 3;
  localparam int PICK_W = 3;
  localparam int SI_NAME = 0;
  localparam int SI_ATTR = 1;
  localparam int SI_UNIT = 2;
  localparam int SI_MIN = 3;
  localparam int SI_MAX = 4;
  localparam int SI_DATA = 5;
  localparam logic [ELEM_W-1:0] ELEM_DATA_ONLY = 8'h40;
  localparam int ATTR_PROC_BIT = 0;
  localparam logic [SLOT_W-1:0] PROC_SLOT = 3'h7;
  localparam logic [DATA_W-1:0] ATTR_PROC = 32'h0000_0001;
  localparam logic [DATA_W-1:0] DEF_MAX = 32'hFFFF_FFFF;

  localparam logic [ERR_CODE_W-1:0] ERR_NONE = 16'h0000;
  localparam logic [ERR_CODE_W-1:0] ERR_NO_PARAM = 16'h1001;
  localparam logic [ERR_CODE_W-1:0] ERR_BAD_ELEM = 16'h1002;
  localparam logic [ERR_CODE_W-1:0] ERR_READ_ONLY = 16'h7002;
  localparam logic [ERR_CODE_W-1:0] ERR_RANGE = 16'h7003;
  localparam logic [ERR_CODE_W-1:0] ERR_BAD_CMD = 16'h0001;

  // ************************************************************
  // host register map
  // ************************************************************
  localparam int PADDR_W = 8;
  localparam logic [PADDR_W-1:0] OFF_CTRL = 8'h00;
  localparam logic [PADDR_W-1:0] OFF_HDR = 8'h04;
  localparam logic [PADDR_W-1:0] OFF_WDATA = 8'h08;
  localparam logic [PADDR_W-1:0] OFF_RDATA = 8'h0C;
  localparam logic [PADDR_W-1:0] OFF_RHDR = 8'h10;
  localparam logic [PADDR_W-1:0] OFF_STATUS = 8'h14;
  localparam logic [PADDR_W-1:0] OFF_ISTAT = 8'h18;
  localparam logic [PADDR_W-1:0] OFF_IMASK = 8'h1C;
  localparam int CTRL_GO_BIT = 0;
  localparam int CTRL_CMD_LO = 1;
  localparam int CTRL_MORE_BIT = 4;
  localparam int HDR_ELEM_LO = 8;
  localparam int HDR_IDENT_LO = 16;
  localparam int RHDR_MORE_BIT = 4;
  localparam int RHDR_ERR_BIT = 5;
  localparam int IRQ_W = 2;
  localparam int IRQ_RSP_BIT = 0;
  localparam int IRQ_ERR_BIT = 1;

endpackage

// ### design/svc_if.sv
// Purpose: mailbox frame carrier between master and slave ends
// Assumes: both ends on sys_clk_in; valid/ready handshakes
// Notes: one request channel, one response channel
`timescale 1ns/100ps
interface svc_if;
  import svc_pkg::*;
  logic req_valid;
  logic req_ready;
  logic [CMD_W-1:0] req_cmd;
  logic req_more;
  logic [ADDR_W-1:0] req_addr;
  logic [ELEM_W-1:0] req_elem;
  logic [IDENT_W-1:0] req_ident;
  logic [DATA_W-1:0] req_data;
  logic rsp_valid;
  logic rsp_ready;
  logic [CMD_W-1:0] rsp_cmd;
  logic rsp_more;
  logic rsp_err;
  logic [ADDR_W-1:0] rsp_addr;
  logic [ELEM_W-1:0] rsp_elem;
  logic [IDENT_W-1:0] rsp_ident;
  logic [DATA_W-1:0] rsp_data;

  modport dev (
    input req_valid, req_cmd, req_more, req_addr, req_elem, req_ident,
    input req_data, rsp_ready,
    output req_ready, rsp_valid, rsp_cmd, rsp_more, rsp_err, rsp_addr,
    output rsp_elem, rsp_ident, rsp_data
  );
  modport host (
    output req_valid, req_cmd, req_more, req_addr, req_elem, req_ident,
    output req_data, rsp_ready,
    input req_ready, rsp_valid, rsp_cmd, rsp_more, rsp_err, rsp_addr,
    input rsp_elem, rsp_ident, rsp_data
  );
endinterface

// ### design/elem_pick.sv
// Purpose: pick the lowest selected element of a mask
// Assumes: combinational, any mask value
// Notes: idx_out is zero when the mask is empty
`timescale 1ns/100ps
module elem_pick
  import svc_pkg::*;
(
  input wire logic [ELEM_W-1:0] mask_in, // element selection
  output logic [ELEM_W-1:0] first_out, // lowest set bit alone
  output logic [PICK_W-1:0] idx_out, // its position
  output logic [ELEM_W-1:0] rest_out // mask without it
);
  assign first_out = mask_in & (~mask_in + ELEM_W'(1));
  assign rest_out = mask_in & ~first_out;

  always_comb begin
    idx_out = '0;
    for (int i = ELEM_W - 1; i >= 0; i--) begin
      if (mask_in[i]) begin
        idx_out = PICK_W'(i);
      end
    end
  end
endmodule

// ### design/service_master.sv
// Purpose: master end of the parameter service channel, APB driven
// Assumes: software builds each frame in registers, then writes go
// Notes: response registers hold until the response bit is cleared
`timescale 1ns/100ps
module service_master
  import svc_pkg::*;
(
  input wire logic sys_clk_in, // 20 MHz clock
  input wire logic rst_b_in, // sync reset, active low
  svc_if.host link, // mailbox frames
  input wire logic psel_in, // apb select
  input wire logic penable_in, // apb enable
  input wire logic pwrite_in, // apb direction
  input wire logic [PADDR_W-1:0] paddr_in, // apb byte address
  input wire logic [DATA_W-1:0] pwdata_in, // apb write data
  output logic [DATA_W-1:0] prdata_out, // apb read data
  output logic pready_out, // apb ready
  output logic pslverr_out, // apb error, unmapped address
  output logic irq_out // level interrupt
);

  logic [DATA_W-1:0] hdr;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] rdata;
  logic [DATA_W-1:0] rhdr;
  logic [IRQ_W-1:0] istat;
  logic [IRQ_W-1:0] imask;
  logic [DATA_W-1:0] rd_mux;

  // ************************************************************
  // bus decode
  // ************************************************************
  wire acc_start = psel_in && penable_in && !pready_out;
  wire wr = psel_in && penable_in && pready_out && pwrite_in;
  wire sel_ctrl = (paddr_in == OFF_CTRL);
  wire sel_hdr = (paddr_in == OFF_HDR);
  wire sel_wdata = (paddr_in == OFF_WDATA);
  wire sel_rdata = (paddr_in == OFF_RDATA);
  wire sel_rhdr = (paddr_in == OFF_RHDR);
  wire sel_status = (paddr_in == OFF_STATUS);
  wire sel_istat = (paddr_in == OFF_ISTAT);
  wire sel_imask = (paddr_in == OFF_IMASK);
  wire mapped = sel_ctrl || sel_hdr || sel_wdata || sel_rdata ||
    sel_rhdr || sel_status || sel_istat || sel_imask;
  // a go while a request is still pending is ignored
  wire go = wr && sel_ctrl && pwdata_in[CTRL_GO_BIT] && !link.req_valid;
  wire rsp_take = link.rsp_valid && link.rsp_ready;
  wire [IRQ_W-1:0] set_bits = {rsp_take && link.rsp_err, rsp_take};
  wire [IRQ_W-1:0] clr_bits = (wr && sel_istat) ?
    pwdata_in[IRQ_W-1:0] : '0;
  // set wins over a clear in the same cycle
  wire [IRQ_W-1:0] next_istat = (istat & ~clr_bits) | set_bits;

  always_comb begin
    rd_mux = '0;
    case (paddr_in)
      OFF_HDR: rd_mux = hdr;
      OFF_WDATA: rd_mux = wdata;
      OFF_RDATA: rd_mux = rdata;
      OFF_RHDR: rd_mux = rhdr;
      OFF_STATUS: rd_mux = DATA_W'(link.req_valid);
      OFF_ISTAT: rd_mux = DATA_W'(istat);
      OFF_IMASK: rd_mux = DATA_W'(imask);
      default: rd_mux = '0;
    endcase
  end

  // ************************************************************
  // bus answer and registers
  // ************************************************************
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out <= '0;
    end else begin
      pready_out <= acc_start;
      pslverr_out <= acc_start && !mapped;
      prdata_out <= acc_start ? rd_mux : '0;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      hdr <= '0;
      wdata <= '0;
      imask <= '0;
    end else begin
      if (wr && sel_hdr) begin
        hdr <= pwdata_in;
      end
      if (wr && sel_wdata) begin
        wdata <= pwdata_in;
      end
      if (wr && sel_imask) begin
        imask <= pwdata_in[IRQ_W-1:0];
      end
    end
  end

  // ************************************************************
  // request issue
  // ************************************************************
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      link.req_valid <= 1'b0;
      link.req_cmd <= '0;
      link.req_more <= 1'b0;
      link.req_addr <= '0;
      link.req_elem <= '0;
      link.req_ident <= '0;
      link.req_data <= '0;
    end else if (go) begin
      // a request leaves only on a software go
      // parameter traffic goes out as a mailbox frame
      link.req_valid <= 1'b1;
      link.req_cmd <= pwdata_in[CTRL_CMD_LO +: CMD_W];
      // follow-on flag set per fragment by software
      // fragments go out one request at a time
      link.req_more <= pwdata_in[CTRL_MORE_BIT];
      // target slave address from the header register
      link.req_addr <= hdr[ADDR_W-1:0];
      // element mask passed through bit for bit
      link.req_elem <= hdr[HDR_ELEM_LO +: ELEM_W];
      // identifier or remaining count, as software set
      // ident field kept whole, 16 bits
      link.req_ident <= hdr[HDR_IDENT_LO +: IDENT_W];
      link.req_data <= wdata;
    end else if (link.req_ready) begin
      link.req_valid <= 1'b0;
    end
  end

  // ************************************************************
  // response capture and interrupt
  // ************************************************************
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      rdata <= '0;
      rhdr <= '0;
      istat <= '0;
      link.rsp_ready <= 1'b0;
      irq_out <= 1'b0;
    end else begin
      if (rsp_take) begin
        rdata <= link.rsp_data;
        rhdr <= {link.rsp_ident, link.rsp_elem, 2'h0,
          link.rsp_err, link.rsp_more, 1'h0, link.rsp_cmd};
      end
      istat <= next_istat;
      // stalls the slave until software has taken the last answer
      link.rsp_ready <= !next_istat[IRQ_RSP_BIT];
      irq_out <= |(next_istat & imask);
    end
  end

endmodule

// ### dv/svc_checker.sv
// Purpose: link checks between master and slave ends
// Assumes: one clock, tb drives the slave's own address
// Notes: instantiated beside the link, no bind
`timescale 1ns/100ps
module svc_checker
  import svc_pkg::*;
(
  input wire logic sys_clk_in, // clock
  input wire logic rst_b_in, // reset
  input wire logic req_valid, // req
  input wire logic req_ready, // req
  input wire logic [CMD_W-1:0] req_cmd, // req
  input wire logic [IDENT_W-1:0] req_ident, // req
  input wire logic rsp_valid, // rsp
  input wire logic rsp_ready, // rsp
  input wire logic [CMD_W-1:0] rsp_cmd, // rsp
  input wire logic rsp_more, // rsp
  input wire logic rsp_err, // rsp
  input wire logic [ELEM_W-1:0] rsp_elem, // rsp
  input wire logic [DATA_W-1:0] rsp_data // rsp
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_b_in);
  sequence s_take;
    req_valid && req_ready;
  endsequence
  sequence s_rd_take;
    s_take and req_cmd == CMD_RD_REQ;
  endsequence
  property p_req_hold;
    req_valid && !req_ready |=>
      req_valid && $stable(req_ident) && $stable(req_cmd);
  endproperty
  a_req_hold: assert property (p_req_hold)
    else $error("request changed before take");
  property p_rsp_hold;
    rsp_valid && !rsp_ready |=>
      rsp_valid && $stable(rsp_data) && $stable(rsp_elem);
  endproperty
  a_rsp_hold: assert property (p_rsp_hold)
    else $error("response changed before take");
  property p_rsp_kind;
    rsp_valid && !rsp_err |->
      rsp_cmd == CMD_RD_RSP || rsp_cmd == CMD_WR_RSP;
  endproperty
  a_rsp_kind: assert property (p_rsp_kind)
    else $error("bad response command");
  property p_wr_last;
    rsp_valid && rsp_cmd == CMD_WR_RSP |-> !rsp_more;
  endproperty
  a_wr_last: assert property (p_wr_last)
    else $error("write response with follow-on");
  property p_err_code;
    rsp_valid && rsp_err |-> rsp_data[15:0] != ERR_NONE;
  endproperty
  a_err_code: assert property (p_err_code)
    else $error("error response without code");
  property p_onehot;
    rsp_valid && rsp_cmd == CMD_RD_RSP && !rsp_err |-> $onehot(rsp_elem);
  endproperty
  a_onehot: assert property (p_onehot)
    else $error("read response element not one-hot");
  property p_free;
    s_take |=> !req_ready ##[1:1000] req_ready;
  endproperty
  a_free: assert property (p_free)
    else $error("channel not freed");
  property p_rd_answer;
    s_rd_take |-> ##[2:1000] rsp_valid;
  endproperty
  a_rd_answer: assert property (p_rd_answer)
    else $error("read request unanswered");
endmodule

// ### dv/servo_param_service_channel_tb_top.sv
// Purpose: self-checking bench, both ends joined by the link
// Assumes: software view through apb only
// Notes: every response is cleared before the next request
`timescale 1ns/100ps
module servo_param_service_channel_tb_top;
  import svc_pkg::*;
  localparam logic [ADDR_W-1:0] SLV = 8'h05;
  logic sys_clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd, hdr, dat;
  logic pready, pslverr, irq, serr, pstart;
  logic [15:0] pident;
  int err_total = 0;
  int num_checks = 0;
  int pulses = 0;
  svc_if link();
  service_slave i_service_slave (.sys_clk_in(sys_clk_in),
    .rst_b_in(rst_b_in), .link(link), .own_addr_in(SLV),
    .proc_start_out(pstart), .proc_ident_out(pident));
  service_master i_service_master (.sys_clk_in(sys_clk_in),
    .rst_b_in(rst_b_in), .link(link), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .irq_out(irq));
  svc_checker i_svc_checker (.sys_clk_in(sys_clk_in),
    .rst_b_in(rst_b_in), .req_valid(link.req_valid),
    .req_ready(link.req_ready), .req_cmd(link.req_cmd),
    .req_ident(link.req_ident), .rsp_valid(link.rsp_valid),
    .rsp_ready(link.rsp_ready), .rsp_cmd(link.rsp_cmd),
    .rsp_more(link.rsp_more), .rsp_err(link.rsp_err),
    .rsp_elem(link.rsp_elem), .rsp_data(link.rsp_data));
  always #25 sys_clk_in = ~sys_clk_in;
  always @(negedge sys_clk_in) if (pstart === 1'b1) pulses++;
  // ************************************************************
  // shared tasks
  // ************************************************************
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_in);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk_in);
    penable <= 1'b1;
    // pready seen as sampled at the edge that commits the access
    @(posedge sys_clk_in);
    while (pready !== 1'b1) @(posedge sys_clk_in);
    rd = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task frame(input logic [2:0] c, input logic m, input logic [7:0] e,
    input logic [15:0] id, input logic [31:0] d);
    apb(1'b1, OFF_HDR, {id, e, SLV});
    apb(1'b1, OFF_WDATA, d);
    apb(1'b1, OFF_CTRL, {27'h000_0000, m, c, 1'b1});
  endtask
  task poll;
    int n;
    n = 0;
    rd = 32'h0000_0000;
    while (rd[0] !== 1'b1 && n < 40) begin
      apb(1'b0, OFF_ISTAT, 32'h0000_0000);
      n++;
    end
    chk("response bit", 32'h0000_0001, {31'h0, rd[0]});
  endtask
  task rsp;
    poll();
    apb(1'b0, OFF_RHDR, 32'h0000_0000);
    hdr = rd;
    apb(1'b0, OFF_RDATA, 32'h0000_0000);
    dat = rd;
    apb(1'b1, OFF_ISTAT, 32'h0000_0003);
  endtask
  task fail_case(input logic [2:0] c, input logic [7:0] e,
    input logic [15:0] id, input logic [15:0] code);
    frame(c, 1'b0, e, id, 32'h0000_0001);
    rsp();
    chk("error flag", 32'h0000_0001, {31'h0, hdr[5]});
    chk("error code", {16'h0000, code}, dat & 32'h0000_FFFF);
  endtask
  // ************************************************************
  // scenarios
  // ************************************************************
  task t_rw;
    frame(CMD_RD_REQ, 1'b0, ELEM_DATA_ONLY, 16'h0003, 32'h0000_0000);
    rsp();
    chk("read header", 32'h0003_4002, hdr);
    frame(CMD_WR_REQ, 1'b0, ELEM_DATA_ONLY, 16'h0003, 32'h0000_0055);
    rsp();
    chk("write header", 32'h0003_0004, hdr & 32'hFFFF_00FF);
    frame(CMD_RD_REQ, 1'b0, ELEM_DATA_ONLY, 16'h0003, 32'h0000_0000);
    rsp();
    chk("read back", 32'h0000_0055, dat);
    $display("test rw done");
  endtask
  task t_multi;
    frame(CMD_RD_REQ, 1'b0, 8'h03, 16'h0002, 32'h0000_0000);
    rsp();
    chk("first header", 32'h0002_0112, hdr);
    chk("ident element", 32'h0000_0002, dat);
    rsp();
    chk("second header", 32'h0002_0202, hdr);
    chk("name element", 32'h0000_0002, dat);
    $display("test multi done");
  endtask
  task t_seg;
    frame(CMD_WR_REQ, 1'b1, ELEM_DATA_ONLY, 16'h0004, 32'h0000_0011);
    frame(CMD_WR_REQ, 1'b1, ELEM_DATA_ONLY, 16'h0001, 32'h0000_0022);
    // two reads so a late answer to the last fragment shows
    apb(1'b0, OFF_ISTAT, 32'h0000_0000);
    apb(1'b0, OFF_ISTAT, 32'h0000_0000);
    chk("no early response", 32'h0000_0000, rd);
    frame(CMD_WR_REQ, 1'b0, ELEM_DATA_ONLY, 16'h0000, 32'h0000_0077);
    rsp();
    chk("seg header", 32'h0004_0004, hdr & 32'hFFFF_00FF);
    frame(CMD_RD_REQ, 1'b0, ELEM_DATA_ONLY, 16'h0004, 32'h0000_0000);
    rsp();
    chk("seg data", 32'h0000_0077, dat);
    $display("test segment done");
  endtask
  task t_err;
    fail_case(CMD_RD_REQ, ELEM_DATA_ONLY, 16'h0100, ERR_NO_PARAM);
    fail_case(CMD_RD_REQ, 8'h00, 16'h0003, ERR_BAD_ELEM);
    fail_case(CMD_WR_REQ, 8'h01, 16'h0003, ERR_READ_ONLY);
    for (int c = 5; c < 8; c++) begin
      fail_case(3'(c), ELEM_DATA_ONLY, 16'h0003, ERR_BAD_CMD);
    end
    frame(CMD_RD_REQ, 1'b0, ELEM_DATA_ONLY, 16'h0003, 32'h0000_0000);
    rsp();
    chk("store kept", 32'h0000_0055, dat);
    $display("test error done");
  endtask
  task t_proc;
    pulses = 0;
    frame(CMD_WR_REQ, 1'b0, ELEM_DATA_ONLY, 16'h0007, 32'h0000_0001);
    rsp();
    chk("start pulses", 32'h0000_0001, 32'(pulses));
    chk("proc ident", 32'h0000_0007, {16'h0000, pident});
    chk("proc header", 32'h0007_0004, hdr & 32'hFFFF_00FF);
    $display("test process done");
  endtask
  task t_irq;
    apb(1'b0, OFF_IMASK, 32'h0000_0000);
    chk("mask reset", 32'h0000_0000, rd);
    apb(1'b1, OFF_IMASK, 32'h0000_0001);
    frame(CMD_RD_REQ, 1'b0, ELEM_DATA_ONLY, 16'h0001, 32'h0000_0000);
    poll();
    chk("irq set", 32'h0000_0001, {31'h0, irq});
    apb(1'b1, OFF_ISTAT, 32'h0000_0003);
    @(negedge sys_clk_in);
    chk("irq clear", 32'h0000_0000, {31'h0, irq});
    apb(1'b0, 8'h20, 32'h0000_0000);
    chk("unmapped", 32'h0000_0001, {31'h0, serr});
    $display("test irq done");
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge sys_clk_in);
    rst_b_in <= 1'b1;
    t_rw();
    t_multi();
    t_seg();
    t_err();
    t_proc();
    t_irq();
    end_of_test();
  end
  // tests need a few hundred cycles, so 40000 is ample
  initial begin
    #2_000_000;
    err_total++;
    end_of_test();
  end
endmodule
